// ### logic/spx_link_if.sv
// serial audio link between source and transmitter input
`timescale 1ns/1ps
`default_nettype none
interface spx_link_if;
    logic sclk;
    logic fsync;
    logic sdata;
    modport source (output sclk, output fsync, output sdata);
    modport sink (input sclk, input fsync, input sdata);
endinterface
`default_nettype wire

// ### logic/spx_pkg.sv
// types shared by both ends of the serial audio link
package spx_pkg;
    typedef logic [1:0] spx_fmt_t;
    typedef logic [1:0] spx_wid_t;
    typedef logic [23:0] spx_word_t;
endpackage

// ### logic/spx_regs.svh
// constants for the serial audio input link of the transmitter
`ifndef SPX_REGS_SVH
`define SPX_REGS_SVH
// ----------------------------------------
// formats and widths
// ----------------------------------------
`define SPX_FMT_LJ 2'h0
`define SPX_FMT_I2S 2'h1
`define SPX_FMT_RJ 2'h2
`define SPX_WW_16 2'h0
`define SPX_WW_18 2'h1
`define SPX_WW_20 2'h2
`define SPX_WW_24 2'h3
// ----------------------------------------
// frame timing in serial clocks; serial clock divider in master clocks
// ----------------------------------------
`define SPX_HALF_BITS 6'h20
`define SPX_RJD_16 6'h10
`define SPX_RJD_18 6'h0E
`define SPX_RJD_20 6'h0C
`define SPX_RJD_24 6'h08
`define SPX_SCLK_DIV 8'h10
`endif

// ### logic/spx_rx.sv
// transmitter serial input stage: captures left and right words
// ----------------------------------------
// Behaviour
// - left-justified, I2S and right-justified formats selectable
// - word widths 16, 18, 20 or 24
// - right-justified: sync high left, low right
// - data sampled on serial clock rising edge
// - rj msb delay 16 clocks@16, 14@18
// - rj msb delay 12 clocks@20, 8@24
// - 64 clocks per frame: rj lsb ends half
// ----------------------------------------
`include "spx_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module spx_rx (
    input wire logic MCLK,
    input wire logic RESET_N,
    spx_link_if.sink LINK,
    input wire spx_pkg::spx_fmt_t FMT,
    input wire spx_pkg::spx_wid_t WID,
    output logic [23:0] LEFT_WORD,
    output logic [23:0] RIGHT_WORD,
    output logic WORD_VALID
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [1:0] sclk_sync_ff;
    logic [1:0] fs_sync_ff;
    logic [1:0] sd_sync_ff;
    logic sclk_d_ff;
    logic fs_d_ff;
    logic sclk_rise;
    logic fs_now;
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            sclk_sync_ff <= 2'h0;
            fs_sync_ff <= 2'h0;
            sd_sync_ff <= 2'h0;
            sclk_d_ff <= 1'h0;
        end else begin
            sclk_sync_ff <= {sclk_sync_ff[0], LINK.sclk};
            fs_sync_ff <= {fs_sync_ff[0], LINK.fsync};
            sd_sync_ff <= {sd_sync_ff[0], LINK.sdata};
            sclk_d_ff <= sclk_sync_ff[1];
        end
    end
    assign sclk_rise = sclk_sync_ff[1] & ~sclk_d_ff;
    assign fs_now = fs_sync_ff[1];
    // ----------------------------------------
    // bit position within half frame
    // ----------------------------------------
    logic [5:0] pos_ff;
    logic [5:0] first_pos;
    logic [4:0] nbits;
    logic [23:0] shift_ff;
    logic [4:0] got_ff;
    logic half_left;
    logic fs_edge;
    assign fs_edge = sclk_rise & (fs_now != fs_d_ff);
    always_comb begin
        case (WID)
            `SPX_WW_16: nbits = 5'h10;
            `SPX_WW_18: nbits = 5'h12;
            `SPX_WW_20: nbits = 5'h14;
            default: nbits = 5'h18;
        endcase
        case (FMT)
            `SPX_FMT_LJ: first_pos = 6'h00;
            `SPX_FMT_I2S: first_pos = 6'h01;
            default: begin
                // rj delay 16 and 18 bit
                // rj delay 20 and 24 bit
                case (WID)
                    `SPX_WW_16: first_pos = `SPX_RJD_16;
                    `SPX_WW_18: first_pos = `SPX_RJD_18;
                    `SPX_WW_20: first_pos = `SPX_RJD_20;
                    default: first_pos = `SPX_RJD_24;
                endcase
            end
        endcase
    end
    // the first sampled bit after the sync edge is position 0
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            pos_ff <= 6'h00;
            fs_d_ff <= 1'h0;
        end else if (sclk_rise) begin
            fs_d_ff <= fs_now;
            pos_ff <= fs_edge ? 6'h01 : pos_ff + 6'h01;
        end
    end
    logic [5:0] cur_pos;
    assign cur_pos = fs_edge ? 6'h00 : pos_ff;
    // rj and lj: high is left; I2S low is left
    assign half_left = (FMT == `SPX_FMT_I2S) ? ~fs_now : fs_now;
    logic left_ff;
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            shift_ff <= 24'h000000;
            got_ff <= 5'h00;
            left_ff <= 1'h0;
        end else if (sclk_rise) begin
            if (cur_pos == first_pos) begin
                shift_ff <= {23'h000000, sd_sync_ff[1]};
                got_ff <= 5'h01;
                left_ff <= half_left;
            end else if (got_ff != 5'h00 && got_ff < nbits) begin
                shift_ff <= {shift_ff[22:0], sd_sync_ff[1]};
                got_ff <= got_ff + 5'h01;
            end else begin
                got_ff <= 5'h00;
            end
        end
    end
    // ----------------------------------------
    // word hand-off, msb aligned to bit 23
    // ----------------------------------------
    logic [23:0] aligned;
    assign aligned = shift_ff << (5'h18 - nbits);
    // flag on the rise that shifts the lsb, so an rj word is handed
    // off before the sync edge that follows it
    logic last_bit;
    assign last_bit = (cur_pos != first_pos) && (got_ff != 5'h00)
        && (got_ff == nbits - 5'h01);
    logic done_ff;
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            done_ff <= 1'h0;
        end else begin
            done_ff <= sclk_rise & last_bit;
        end
    end
    // rj word completes at half-frame end
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            LEFT_WORD <= 24'h000000;
            RIGHT_WORD <= 24'h000000;
            WORD_VALID <= 1'h0;
        end else begin
            WORD_VALID <= done_ff & ~left_ff;
            if (done_ff && left_ff) begin
                LEFT_WORD <= aligned;
            end
            if (done_ff && !left_ff) begin
                RIGHT_WORD <= aligned;
            end
        end
    end
endmodule
`default_nettype wire

// ### logic/spx_src.sv
// serial audio source: divider clock, frame sync and data out
`include "spx_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module spx_src (
    input wire logic MCLK,
    input wire logic RESET_N,
    spx_link_if.source LINK,
    input wire spx_pkg::spx_fmt_t FMT,
    input wire spx_pkg::spx_wid_t WID,
    input wire logic [23:0] LEFT_IN,
    input wire logic [23:0] RIGHT_IN,
    output logic TAKE
);
    // ----------------------------------------
    // serial clock divider
    // ----------------------------------------
    logic [7:0] div_ff;
    logic sclk_ff;
    logic fall;
    assign fall = (div_ff == (`SPX_SCLK_DIV / 8'h02 - 8'h01)) & sclk_ff;
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            div_ff <= 8'h00;
            sclk_ff <= 1'h0;
        end else if (div_ff == (`SPX_SCLK_DIV / 8'h02 - 8'h01)) begin
            div_ff <= 8'h00;
            sclk_ff <= ~sclk_ff;
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end
    // ----------------------------------------
    // 64 clocks per frame, drive on falling edge
    // ----------------------------------------
    logic [5:0] cnt_ff;
    logic [4:0] nbits;
    logic [5:0] first_pos;
    logic [23:0] l_ff;
    logic [23:0] r_ff;
    logic fs_ff;
    logic sd_ff;
    logic [5:0] half_pos;
    logic [5:0] idx;
    logic in_word;
    logic second_half;
    always_comb begin
        case (WID)
            `SPX_WW_16: nbits = 5'h10;
            `SPX_WW_18: nbits = 5'h12;
            `SPX_WW_20: nbits = 5'h14;
            default: nbits = 5'h18;
        endcase
        case (FMT)
            `SPX_FMT_LJ: first_pos = 6'h00;
            `SPX_FMT_I2S: first_pos = 6'h01;
            default: first_pos = `SPX_HALF_BITS - {1'h0, nbits};
        endcase
    end
    logic [5:0] nxt_cnt;
    assign nxt_cnt = cnt_ff + 6'h01;
    assign second_half = nxt_cnt[5];
    assign half_pos = {1'h0, nxt_cnt[4:0]};
    assign idx = half_pos - first_pos;
    assign in_word = (half_pos >= first_pos) && (idx < {1'h0, nbits});
    logic [23:0] word;
    // frame-start bit reads the input: l_ff only loads on that edge
    assign word = second_half ? r_ff : ((nxt_cnt == 6'h00) ? LEFT_IN : l_ff);
    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            cnt_ff <= 6'h3F;
            fs_ff <= 1'h1;
            sd_ff <= 1'h0;
            l_ff <= 24'h000000;
            r_ff <= 24'h000000;
            TAKE <= 1'h0;
        end else begin
            TAKE <= fall & (nxt_cnt == 6'h00);
            if (fall) begin
                cnt_ff <= nxt_cnt;
                if (nxt_cnt == 6'h00) begin
                    l_ff <= LEFT_IN;
                    r_ff <= RIGHT_IN;
                end
                fs_ff <= (FMT == `SPX_FMT_I2S) ? second_half : ~second_half;
                sd_ff <= in_word ? word[5'h17 - idx[4:0]] : 1'h0;
            end
        end
    end
    assign LINK.sclk = sclk_ff;
    assign LINK.fsync = fs_ff;
    assign LINK.sdata = sd_ff;
endmodule
`default_nettype wire

// ### verification/spdif_tx_serial_input_tb.sv
// bench joining source and input stage over the link
`include "spx_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module spdif_tx_serial_input_tb;
    // ----
    // setup
    // ----
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    spx_pkg::spx_fmt_t fmt = 2'h0;
    spx_pkg::spx_wid_t wid = 2'h0;
    logic [23:0] left_in = 24'h0;
    logic [23:0] right_in = 24'h0;
    logic [23:0] left_word;
    logic [23:0] right_word;
    logic wv;
    logic take;
    int n_take = 0;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;
    spx_link_if lnk ();
    spx_src u_spx_src (.MCLK(mclk), .RESET_N(reset_n), .LINK(lnk.source),
        .FMT(fmt), .WID(wid), .LEFT_IN(left_in), .RIGHT_IN(right_in),
        .TAKE(take));
    spx_rx u_spx_rx (.MCLK(mclk), .RESET_N(reset_n), .LINK(lnk.sink),
        .FMT(fmt), .WID(wid), .LEFT_WORD(left_word),
        .RIGHT_WORD(right_word), .WORD_VALID(wv));
    spx_link_props u_spx_link_props (.MCLK(mclk), .RESET_N(reset_n),
        .sclk(lnk.sclk), .fsync(lnk.fsync), .sdata(lnk.sdata), .FMT(fmt),
        .WORD_VALID(wv));
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        if (take === 1'b1)
            n_take++;
    end
    // ceiling allows some 19 cases of four frames; 12 are run
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 80000) begin
            n_fail++;
            summarize();
        end
    end
    task automatic chk(input string what, input logic [23:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic wait_wv();
        int i;
        for (i = 0; i < 2500 && wv !== 1'b1; i++)
            @(negedge mclk);
        chk("valid", {23'h0, wv}, 24'h1);
        @(negedge mclk);
    endtask
    // narrow words keep msb at bit 23, low bits zero
    task automatic run_case(input spx_pkg::spx_fmt_t f, input int w);
        logic [23:0] m;
        int k;
        m = ~(24'hFFFFFF >> ((w == 3) ? 24 : 16 + 2 * w));
        @(posedge mclk);
        reset_n <= 1'b0;
        fmt <= f;
        wid <= w[1:0];
        left_in <= 24'hA5C3E1;
        right_in <= 24'h3C5A96;
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (2) wait_wv();
        k = n_take;
        chk("left", left_word, 24'hA5C3E1 & m);
        chk("right", right_word, 24'h3C5A96 & m);
        @(posedge mclk);
        left_in <= 24'h5A3C1E;
        right_in <= 24'hC3A569;
        repeat (2) wait_wv();
        chk("left2", left_word, 24'h5A3C1E & m);
        chk("right2", right_word, 24'hC3A569 & m);
        chk("take", 24'(n_take - k), 24'h000002);
    endtask
    task automatic test_lj();
        for (int w = 0; w < 4; w++)
            run_case(`SPX_FMT_LJ, w);
        $display("test_lj done");
    endtask
    task automatic test_i2s();
        for (int w = 0; w < 4; w++)
            run_case(`SPX_FMT_I2S, w);
        $display("test_i2s done");
    endtask
    task automatic test_rj();
        for (int w = 0; w < 4; w++)
            run_case(`SPX_FMT_RJ, w);
        $display("test_rj done");
    endtask
    task automatic summarize();
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        test_lj();
        test_i2s();
        test_rj();
        summarize();
    end
endmodule
`default_nettype wire

// ### verification/spx_link_props.sv
// wire checks for the serial audio link
`include "spx_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module spx_link_props (
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic sclk,
    input wire logic fsync,
    input wire logic sdata,
    input wire spx_pkg::spx_fmt_t FMT,
    input wire logic WORD_VALID
);
    // ----
    // helpers
    // ----
    logic fs_q;
    logic [5:0] cnt_ff;
    logic [1:0] nfs_ff;
    logic [7:0] age_ff;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    always_ff @(posedge MCLK) fs_q <= fsync;
    // serial clock rises since last sync edge
    always_ff @(posedge MCLK) begin
        if (!RESET_N || fsync != fs_q)
            cnt_ff <= 6'h00;
        else if ($rose(sclk))
            cnt_ff <= cnt_ff + 6'h01;
    end
    // first sync edges after reset are not aligned yet
    always_ff @(posedge MCLK) begin
        if (!RESET_N)
            nfs_ff <= 2'h0;
        else if (fsync != fs_q && nfs_ff != 2'h3)
            nfs_ff <= nfs_ff + 2'h1;
    end
    always_ff @(posedge MCLK) begin
        if (!RESET_N || WORD_VALID)
            age_ff <= 8'h00;
        else if (age_ff != 8'hFF)
            age_ff <= age_ff + 8'h01;
    end
    // ----
    // assertions
    // ----
    AST_SCLK_HIGH: assert property ($rose(sclk) |-> ##8 $fell(sclk))
        else $error("serial clock high phase wrong");
    AST_SCLK_LOW: assert property ($fell(sclk) |-> ##8 $rose(sclk))
        else $error("serial clock low phase wrong");
    AST_DATA_ON_FALL: assert property ($changed(sdata) && nfs_ff != 2'h0
        |-> $fell(sclk)) else $error("data moved off falling edge");
    AST_SYNC_ON_FALL: assert property ($changed(fsync) && nfs_ff != 2'h0
        |-> $fell(sclk)) else $error("sync moved off falling edge");
    AST_FRAME_HALF: assert property ($changed(fsync) && nfs_ff != 2'h0
        |-> cnt_ff == 6'h20) else $error("half frame not 32 clocks");
    AST_VALID_PULSE: assert property (WORD_VALID |=> !WORD_VALID [*8])
        else $error("word valid too long");
    AST_VALID_SIDE: assert property ($rose(WORD_VALID)
        |-> fsync == (FMT == `SPX_FMT_I2S)) else $error("word on wrong side");
    AST_RJ_END: assert property (FMT == `SPX_FMT_RJ && $rose(fsync)
        && nfs_ff == 2'h3 |-> age_ff < 8'h0A) else $error("rj lsb late");
endmodule
`default_nettype wire
